// *** dpio_defs.svh ***
// dpio_defs.svh: widths, reset values and sizes for the dual port data register.
// assumes: included by bare name from the package and the design modules.
`ifndef DPIO_DEFS_SVH
`define DPIO_DEFS_SVH

`define DPIO_WIDTH        8
`define DPIO_LATCH_RST    8'hFF
`define DPIO_STRAP_FAIL   8'h00
`define DPIO_STATUS_RST   1'b0
`define DPIO_LOG_DEPTH    32
`define DPIO_LOG_AW       5
`define DPIO_SRC_USER     1'b1
`define DPIO_SRC_HOST     1'b0

`endif

// *** dpio_far_end.sv ***
// dpio_far_end.sv: host bus and user equipment standing beside the data register.
// assumes: the bench says when each side drives; register pins split into o and oe.
module dpio_far_end (
  input  wire logic       clk,
  input  wire logic       udrv,
  input  wire logic [7:0] uval,
  input  wire logic       hdrv,
  input  wire logic [7:0] hval,
  input  wire logic [7:0] uo,
  input  wire logic [7:0] uoe,
  input  wire logic [7:0] ho,
  input  wire logic [7:0] hoe,
  output logic [7:0]      uw,
  output logic [7:0]      hw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ulast = 8'h00;
  logic [7:0] hlast = 8'h00;
  // a released line shows the inverse of its last level, so stale data never passes
  assign uw = (uoe & uo) | (~uoe & (udrv ? uval : ~ulast));
  assign hw = (hoe & ho) | (~hoe & (hdrv ? hval : ~hlast));
  always @(posedge clk)
  begin
    ulast <= uw;
    hlast <= hw;
  end
endmodule

// *** dpio_fifo.sv ***
// dpio_fifo.sv: synchronous FIFO, width and depth by parameter, valid/ready both sides.
// assumes: single clock; ce low freezes all state.
`include "dpio_defs.svh"

module dpio_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `DPIO_LOG_DEPTH,
  parameter int AW    = `DPIO_LOG_AW
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } dpio_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  dpio_fifo_st_t    st;
  dpio_fifo_st_t    next_st;
  logic             push;
  logic             pop;

  always_comb
  begin
    in_ready  = (st.count != (AW+1)'(DEPTH));
    out_valid = (st.count != '0);
    out_data  = mem[st.rd];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    next_st   = st;
    if (push)
      next_st.wr = st.wr + 1'b1;
    if (pop)
      next_st.rd = st.rd + 1'b1;
    if (push && !pop)
      next_st.count = st.count + 1'b1;
    else if (pop && !push)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  // storage carries no reset: a word is only read after it was written
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[st.wr] <= in_data;
  end

endmodule

// *** dpio_pkg.sv ***
// dpio_pkg.sv: types shared by the dual port data register modules.
// assumes: dpio_defs.svh is on the include path.
`include "dpio_defs.svh"

package dpio_pkg;

  typedef enum logic [0:0] {
    ST_STRAP,
    ST_RUN
  } dpio_phase_t;

  typedef struct packed {
    logic latch_clk;
    logic host_port_enable_n;
    logic host_write_cmd;
    logic host_read_cmd_n;
    logic user_input_strobe_n;
    logic user_output_enable_n;
  } dpio_ctrl_t;

  typedef struct packed {
    logic user_load;
    logic user_drive;
    logic host_load;
    logic host_drive;
  } dpio_dec_t;

  typedef struct packed {
    logic                    src;
    logic [`DPIO_WIDTH-1:0]  value;
  } dpio_log_t;

endpackage

// *** dpio_port_ctrl.sv ***
// dpio_port_ctrl.sv: decodes the control pins of both ports into load and drive terms.
// assumes: all inputs synchronous to clk; status is the already combined host select.
`include "dpio_defs.svh"

module dpio_port_ctrl (
  input  wire dpio_pkg::dpio_ctrl_t ctrl,
  input  wire logic                 running,
  input  wire logic                 host_sel,
  output dpio_pkg::dpio_dec_t       dec
);

  logic host_active;

  always_comb
  begin
    host_active    = running & ~ctrl.host_port_enable_n & host_sel;
    dec.user_drive = ~ctrl.user_output_enable_n;
    dec.user_load  = running & ~ctrl.user_input_strobe_n & ctrl.latch_clk;
    dec.host_drive = host_active & ~ctrl.host_read_cmd_n & ~ctrl.host_write_cmd;
    // a low user strobe blocks host input even with the latch clock high
    dec.host_load  = host_active & ctrl.host_write_cmd & ctrl.latch_clk
                     & ctrl.user_input_strobe_n;
  end

endmodule

// *** dpio_register.sv ***
// dpio_register.sv: eight-bit data register shared by a host port and a user port.
// assumes: every input synchronous to clk; the latch clock is an ordinary sampled
// input; pins are split into in, out and enable and resolved outside.
`include "dpio_defs.svh"

// What this block does
// [R01] one set of eight data latches, read and written from either port
// [R02] simultaneous writes from both ports: user data wins, host write dropped
// [R03] host enable high makes the host port idle; user port unaffected
// [R04] latch clock low at start: user outputs all ones, host lines undriven
// [R05] user output enable low drives the latches onto the user lines
// [R06] low user strobe loads user lines only while latch clock is high
// [R07] low user strobe blocks every host write into the latches
// [R08] host drives latches out when enable, read and write are all low
// [R09] host stores its lines when enabled, write high, clock high, strobe high
// [R10] host activity is further gated by an internal status latch
// [R11] data crossing from one port to the other reads back inverted
// [R12] data read back on the port that wrote it is not inverted
// [R13] apart from write priority the two ports act independently
// [R14] host never raises read and write together; keeps clock low at start
module dpio_register (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   latch_clk,
  input  wire logic                   host_port_enable_n,
  input  wire logic                   host_write_cmd,
  input  wire logic                   host_read_cmd_n,
  input  wire logic                   user_input_strobe_n,
  input  wire logic                   user_output_enable_n,
  input  wire logic [`DPIO_WIDTH-1:0] user_side_data_lines_i,
  output logic [`DPIO_WIDTH-1:0]      user_side_data_lines_o,
  output logic [`DPIO_WIDTH-1:0]      user_side_data_lines_oe,
  input  wire logic [`DPIO_WIDTH-1:0] host_side_data_lines_i,
  output logic [`DPIO_WIDTH-1:0]      host_side_data_lines_o,
  output logic [`DPIO_WIDTH-1:0]      host_side_data_lines_oe,
  output logic                        log_valid,
  input  wire logic                   log_ready,
  output dpio_pkg::dpio_log_t         log_data
);

  typedef struct packed {
    dpio_pkg::dpio_phase_t   phase;
    logic [`DPIO_WIDTH-1:0]  data;
    logic [`DPIO_WIDTH-1:0]  host_view;
    logic                    status;
  } dpio_st_t;

  dpio_st_t             st;
  dpio_st_t             next_st;
  dpio_pkg::dpio_ctrl_t ctrl;
  dpio_pkg::dpio_dec_t  dec;
  dpio_pkg::dpio_log_t  log_in;
  logic                 running;
  logic                 sel_now;
  logic                 log_room;
  logic                 wr_user;
  logic                 wr_host;

  // host view is stored inverted, so the host bus reads active low
  function automatic logic [`DPIO_WIDTH-1:0] to_host(input logic [`DPIO_WIDTH-1:0] v);
    return ~v;
  endfunction

  always_comb
  begin
    ctrl.latch_clk            = latch_clk;
    ctrl.host_port_enable_n   = host_port_enable_n;
    ctrl.host_write_cmd       = host_write_cmd;
    ctrl.host_read_cmd_n      = host_read_cmd_n;
    ctrl.user_input_strobe_n  = user_input_strobe_n;
    ctrl.user_output_enable_n = user_output_enable_n;
    running                   = (st.phase == dpio_pkg::ST_RUN);
  end

  // a selecting clock edge counts in the same cycle, so a host write on the
  // first selected clock is not lost
  always_comb
  begin
    if (latch_clk)
      sel_now = ~host_port_enable_n; // [R10]
    else
      sel_now = st.status;
  end

  dpio_port_ctrl u_ctrl (
    .ctrl    (ctrl),
    .running (running),
    .host_sel(sel_now),
    .dec     (dec)
  );

  // every port write into the latches is logged (the start-up load is not); a full
  // log holds off both writers so that no port write goes unrecorded
  always_comb
  begin
    wr_user = dec.user_load & log_room;                 // [R06]
    wr_host = dec.host_load & ~dec.user_load & log_room; // [R02] [R07]
  end

  always_comb
  begin
    next_st = st;
    log_in  = '0;
    case (st.phase)
      dpio_pkg::ST_STRAP:
      begin
        // latch clock high at start gives no defined state; clear instead
        if (latch_clk)
          next_st.data = `DPIO_STRAP_FAIL;
        else
          next_st.data = `DPIO_LATCH_RST; // [R04]
        next_st.phase = dpio_pkg::ST_RUN;
      end
      dpio_pkg::ST_RUN:
      begin
        if (latch_clk)
          next_st.status = ~host_port_enable_n; // [R10]
        if (wr_user)
        begin
          next_st.data = user_side_data_lines_i; // [R02] [R12]
          log_in.src   = `DPIO_SRC_USER;
          log_in.value = user_side_data_lines_i;
        end
        else if (wr_host)
        begin
          next_st.data = to_host(host_side_data_lines_i); // [R09] [R11]
          log_in.src   = `DPIO_SRC_HOST;
          log_in.value = to_host(host_side_data_lines_i);
        end
      end
      default:
      begin
        next_st.phase = dpio_pkg::ST_STRAP;
      end
    endcase
    next_st.host_view = to_host(next_st.data); // [R11] [R12]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st.phase     <= dpio_pkg::ST_STRAP;
      st.data      <= `DPIO_LATCH_RST;
      st.host_view <= ~`DPIO_LATCH_RST;
      st.status    <= `DPIO_STATUS_RST;
    end
    else if (ce)
      st <= next_st; // [R01]
  end

  dpio_fifo #(
    .WIDTH($bits(dpio_pkg::dpio_log_t)),
    .DEPTH(`DPIO_LOG_DEPTH),
    .AW   (`DPIO_LOG_AW)
  ) u_log (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .in_valid (wr_user | wr_host),
    .in_ready (log_room),
    .in_data  (log_in),
    .out_valid(log_valid),
    .out_ready(log_ready),
    .out_data (log_data)
  );

  // the user side never looks at host controls and vice versa
  always_comb
  begin
    user_side_data_lines_o  = st.data;
    user_side_data_lines_oe = {`DPIO_WIDTH{dec.user_drive}}; // [R05] [R13]
    host_side_data_lines_o  = st.host_view;
    host_side_data_lines_oe = {`DPIO_WIDTH{dec.host_drive}}; // [R03] [R08]
  end

  // ---- checks ----

  logic [`DPIO_WIDTH-1:0] user_in_d;
  logic [`DPIO_WIDTH-1:0] host_in_d;
  logic                   user_wr_d;
  logic                   host_wr_d;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      user_in_d <= '0;
      host_in_d <= '0;
      user_wr_d <= 1'b0;
      host_wr_d <= 1'b0;
    end
    else
    begin
      user_in_d <= user_side_data_lines_i;
      host_in_d <= host_side_data_lines_i;
      user_wr_d <= ce & wr_user;
      host_wr_d <= ce & wr_host;
    end
  end

  a_latch_hold: assert property ( // [R01]
    @(posedge clk) disable iff (!nrst)
    (running && (!ce || (!dec.user_load && !dec.host_load))) |=> $stable(st.data)
  ) else $error("latches changed with no write");

  a_user_prio: assert property ( // [R02]
    @(posedge clk) disable iff (!nrst)
    (ce && dec.user_load && log_room && !host_port_enable_n && sel_now && host_write_cmd)
      |=> (user_side_data_lines_o == $past(user_side_data_lines_i))
  ) else $error("host write beat user write");

  a_enable_idle: assert property ( // [R03]
    @(posedge clk) disable iff (!nrst)
    host_port_enable_n |-> (host_side_data_lines_oe == '0) && !dec.host_load
  ) else $error("host port active while disabled");

  a_powerup_ones: assert property ( // [R04]
    @(posedge clk) disable iff (!nrst)
    (ce && !running && !latch_clk)
      |=> (user_side_data_lines_o == `DPIO_LATCH_RST) && running
  ) else $error("start state is not all ones");

  a_powerup_hiz: assert property ( // [R04]
    @(posedge clk) disable iff (!nrst)
    !running |-> (host_side_data_lines_oe == '0)
  ) else $error("host lines driven before start");

  a_user_drive: assert property ( // [R05]
    @(posedge clk) disable iff (!nrst)
    (user_side_data_lines_oe == {`DPIO_WIDTH{1'b1}}) == !user_output_enable_n
  ) else $error("user drive does not follow enable");

  a_user_clk: assert property ( // [R06]
    @(posedge clk) disable iff (!nrst)
    (ce && running && !latch_clk) |=> $stable(st.data)
  ) else $error("latch loaded with latch clock low");

  a_strobe_block: assert property ( // [R07]
    @(posedge clk) disable iff (!nrst)
    !user_input_strobe_n |-> !wr_host
  ) else $error("host wrote under user strobe");

  a_host_read: assert property ( // [R08]
    @(posedge clk) disable iff (!nrst)
    (running && !host_port_enable_n && sel_now && !host_read_cmd_n && !host_write_cmd)
      |-> (host_side_data_lines_oe == {`DPIO_WIDTH{1'b1}})
  ) else $error("host read not driven");

  a_host_store: assert property ( // [R09]
    @(posedge clk) disable iff (!nrst)
    (ce && running && sel_now && !host_port_enable_n && host_write_cmd && latch_clk
      && user_input_strobe_n && log_room) |=> host_wr_d
  ) else $error("host write not taken");

  a_status_gate: assert property ( // [R10]
    @(posedge clk) disable iff (!nrst)
    !sel_now |-> (host_side_data_lines_oe == '0) && !dec.host_load
  ) else $error("host active with status latch clear");

  a_cross_invert: assert property ( // [R11]
    @(posedge clk) disable iff (!nrst)
    host_wr_d |-> (user_side_data_lines_o == ~host_in_d)
  ) else $error("host data not inverted at user port");

  a_same_port: assert property ( // [R12]
    @(posedge clk) disable iff (!nrst)
    user_wr_d |-> (user_side_data_lines_o == user_in_d)
      && (host_side_data_lines_o == ~user_in_d)
  ) else $error("user data altered on readback");

  a_port_indep: assert property ( // [R13]
    @(posedge clk) disable iff (!nrst)
    (ce && dec.host_drive && !dec.user_load) |=> $stable(st.data)
  ) else $error("host read disturbed the latches");

  a_freeze: assert property (
    @(posedge clk) disable iff (!nrst)
    !ce |=> $stable(st)
  ) else $error("state moved with clock enable low");

  a_log_order: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && !log_room && (dec.user_load || dec.host_load)) |=> $stable(st.data)
  ) else $error("write taken with log full");

  // decode and start-up checks that need no helper flops

  a_host_oe_whole: assert property ( // [R08]
    @(posedge clk) disable iff (!nrst)
    (host_side_data_lines_oe == '0) || (host_side_data_lines_oe == '1)
  ) else $error("host drive enables split");

  a_user_oe_whole: assert property ( // [R05]
    @(posedge clk) disable iff (!nrst)
    (user_side_data_lines_oe == '0) || (user_side_data_lines_oe == '1)
  ) else $error("user drive enables split");

  a_view_inverse: assert property ( // [R11]
    @(posedge clk) disable iff (!nrst)
    host_side_data_lines_o == ~user_side_data_lines_o
  ) else $error("host view is not the inverse of the latches");

  a_user_take: assert property ( // [R06]
    @(posedge clk) disable iff (!nrst)
    (ce && running && !user_input_strobe_n && latch_clk && log_room)
      |=> (user_side_data_lines_o == $past(user_side_data_lines_i))
  ) else $error("user write not taken");

  a_rw_no_drive: assert property ( // [R08]
    @(posedge clk) disable iff (!nrst)
    (!host_read_cmd_n && host_write_cmd) |-> (host_side_data_lines_oe == '0)
  ) else $error("host drove during a write");

  a_log_push: assert property ( // [R01]
    @(posedge clk) disable iff (!nrst)
    (ce && (wr_user || wr_host)) |=> log_valid
  ) else $error("latch update not logged");

  a_status_set: assert property ( // [R10]
    @(posedge clk) disable iff (!nrst)
    (ce && running && latch_clk && !host_port_enable_n) |=> st.status
  ) else $error("status latch not set");

  a_status_clear: assert property ( // [R10]
    @(posedge clk) disable iff (!nrst)
    (ce && running && latch_clk && host_port_enable_n) |=> !st.status
  ) else $error("status latch not cleared");

  a_strap_zero: assert property ( // [R04]
    @(posedge clk) disable iff (!nrst)
    (ce && !running && latch_clk)
      |=> (user_side_data_lines_o == `DPIO_STRAP_FAIL) && running
  ) else $error("start with clock high not cleared");

  a_strap_no_write: assert property ( // [R04]
    @(posedge clk) disable iff (!nrst)
    !running |-> !wr_user && !wr_host
  ) else $error("write taken before start");

  a_host_load_gate: assert property ( // [R09]
    @(posedge clk) disable iff (!nrst)
    dec.host_load
      |-> running && !host_port_enable_n && host_write_cmd && latch_clk && user_input_strobe_n
  ) else $error("host load without its qualifiers");

endmodule

// *** dpio_register_test.sv ***
// dpio_register_test.sv: self-checking bench for the dual port data register.
// assumes: dpio_pkg and dpio_far_end are compiled first; one 10 MHz clock.
module dpio_register_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic                lclk, hen_n, hwr, hrd_n, usb_n, uoe_n, udrv, hdrv, lr, lv, ce;
  logic [7:0]          uval, hval, uw, hw, uo, uoe, ho, hoe;
  dpio_pkg::dpio_log_t ld;
  int                  n_errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;

  always #50 clk = ~clk;

  dpio_register dut (.clk(clk), .nrst(nrst), .ce(ce), .latch_clk(lclk),
    .host_port_enable_n(hen_n), .host_write_cmd(hwr), .host_read_cmd_n(hrd_n),
    .user_input_strobe_n(usb_n), .user_output_enable_n(uoe_n),
    .user_side_data_lines_i(uw), .user_side_data_lines_o(uo),
    .user_side_data_lines_oe(uoe), .host_side_data_lines_i(hw),
    .host_side_data_lines_o(ho), .host_side_data_lines_oe(hoe),
    .log_valid(lv), .log_ready(lr), .log_data(ld));

  dpio_far_end far (.clk(clk), .udrv(udrv), .uval(uval), .hdrv(hdrv), .hval(hval),
    .uo(uo), .uoe(uoe), .ho(ho), .hoe(hoe), .uw(uw), .hw(hw));

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // host read and write are never raised together here
  task automatic idle;
    lclk = 1'b0;
    hen_n = 1'b1;
    hwr = 1'b0;
    hrd_n = 1'b1;
    usb_n = 1'b1;
    udrv = 1'b0;
    hdrv = 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_reset;
    chk(uo, 8'hFF);
    chk(hoe, 8'h00);
    nrst = 1'b1;
    step(2);
    chk(uo, 8'hFF);  // latch clock held low through start
    hen_n = 1'b0;
    hrd_n = 1'b0;
    #1;
    chk(hoe, 8'h00);  // status latch still clear
    step(1);
    idle();
    $display("test reset done");
  endtask

  task automatic t_host;
    lr = 1'b0;
    hen_n = 1'b0;
    hwr = 1'b1;
    lclk = 1'b1;
    hdrv = 1'b1;
    hval = 8'h0F;
    step(1);
    chk(uo, 8'hF0);
    chk(lv, 1'b1);
    chk(ld, {1'b0, 8'hF0});
    lr = 1'b1;
    hwr = 1'b0;
    lclk = 1'b0;
    hdrv = 1'b0;
    hrd_n = 1'b0;
    #1;
    chk(hoe, 8'hFF);
    chk(hw, 8'h0F);
    step(1);
    hen_n = 1'b1;
    hrd_n = 1'b1;
    hwr = 1'b1;
    lclk = 1'b1;
    hdrv = 1'b1;
    hval = 8'h55;
    step(1);
    chk(uo, 8'hF0);  // disabled host port stores nothing
    hdrv = 1'b0;
    hwr = 1'b0;
    hrd_n = 1'b0;
    uoe_n = 1'b0;
    #1;
    chk(hoe, 8'h00);
    chk(uoe, 8'hFF);  // user port unaffected
    chk(uw, 8'hF0);
    step(1);
    idle();
    uoe_n = 1'b1;
    $display("test host done");
  endtask

  task automatic t_user;
    usb_n = 1'b0;
    udrv = 1'b1;
    uval = 8'h33;
    hen_n = 1'b0;
    hrd_n = 1'b0;
    step(1);
    chk(uo, 8'hF0);  // strobe without latch clock loads nothing
    chk(hoe, 8'h00);  // status cleared by a deselecting clock
    lclk = 1'b1;
    uval = 8'h5A;
    step(1);
    chk(uo, 8'h5A);
    usb_n = 1'b1;
    udrv = 1'b0;
    hen_n = 1'b0;
    hrd_n = 1'b0;
    uoe_n = 1'b0;
    #1;
    chk(hoe, 8'hFF);
    chk(hw, 8'hA5);
    chk(uw, 8'h5A);
    step(1);
    idle();
    uoe_n = 1'b1;
    #1;
    chk(uoe, 8'h00);
    step(1);
    $display("test user done");
  endtask

  task automatic t_prio;
    hen_n = 1'b0;
    hwr = 1'b1;
    lclk = 1'b1;
    hdrv = 1'b1;
    hval = 8'h66;
    usb_n = 1'b0;
    udrv = 1'b1;
    uval = 8'h3C;
    step(1);
    chk(uo, 8'h3C);
    usb_n = 1'b1;
    udrv = 1'b0;
    step(1);
    chk(uo, 8'h99);
    idle();
    $display("test priority done");
  endtask

  task automatic t_fifo;
    step(3);
    lr = 1'b0;
    usb_n = 1'b0;
    lclk = 1'b1;
    udrv = 1'b1;
    for (int i = 0; i < 33; i++)
    begin
      uval = 8'(16 + i);
      step(1);
    end
    chk(uo, 8'h2F);  // full log holds the last write off
    idle();
    for (int i = 0; i < 32; i++)
    begin
      lr = 1'b0;
      step(1);
      lr = 1'b1;
      chk(lv, 1'b1);
      chk(ld, {1'b1, 8'(16 + i)});
      step(1);
    end
    chk(lv, 1'b0);
    $display("test fifo done");
  endtask

  task automatic t_freeze;
    lr = 1'b0;
    usb_n = 1'b0;
    lclk = 1'b1;
    udrv = 1'b1;
    uval = 8'h81;
    step(1);
    chk(uo, 8'h81);
    ce = 1'b0;
    lr = 1'b1;
    uval = 8'h7E;
    step(2);
    chk(uo, 8'h81);  // clock enable low holds the latches
    chk(lv, 1'b1);
    chk(ld, {1'b0, 8'h99});  // log frozen as well
    ce = 1'b1;
    idle();
    $display("test freeze done");
  endtask

  task automatic t_strap;
    lr = 1'b0;
    usb_n = 1'b0;
    lclk = 1'b1;
    udrv = 1'b1;
    uval = 8'hC3;
    step(1);
    chk(lv, 1'b1);
    nrst = 1'b0;
    usb_n = 1'b1;
    udrv = 1'b0;
    #1;
    chk(uo, 8'hFF);
    chk(lv, 1'b0);
    step(1);
    nrst = 1'b1;
    step(2);
    chk(uo, 8'h00);  // latch clock high through start gives no ones
    chk(hoe, 8'h00);
    idle();
    lr = 1'b1;
    $display("test strap done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    idle();
    ce = 1'b1;
    uoe_n = 1'b1;
    lr = 1'b1;
    uval = 8'h00;
    hval = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    t_reset();
    t_host();
    t_user();
    t_prio();
    t_freeze();
    t_fifo();
    t_strap();
    tally_and_finish();
  end
endmodule
